// file: src/task_switch_guard.sv
// task switch trap and task state block field access for long mode
// Function
// - in 64-bit mode a jump, call, software or hardware interrupt aimed at a task block or gate faults.
// - in 64-bit mode an interrupt return with the nested task flag at 1 faults.
// - the block holds a 64-bit ring stack pointer for levels 0-2, level 0 low half at byte 4.
// - the block holds seven 64-bit alternate interrupt stack pointers, each as low and high 32-bit halves.
// - the io map base is a 16-bit byte offset from the block base, in the upper half of the last word.
// - the task register loaded in 64-bit mode points at one 64-bit block for all long mode programs.
// - the legacy block has link 0, stacks 2-12, ip 14, flags 16, registers 18-32, selectors 34-40, local table 42.
// - saving into a legacy block drops the upper 16 bits of flags and instruction pointer.
`timescale 1ns/1ps
module task_switch_guard (
  input wire logic clk, // core clock
  input wire logic reset_n, // async reset, active low
  input wire logic long_mode, // core executes in 64-bit mode
  input wire logic nested_task_flag, // nested task flag of flags_register
  input wire task_block_pkg::xfer_req_t xfer, // control transfer under check
  output logic gp_fault_q, // general_protection_fault pulse
  output logic task_switch_q, // permitted hardware task switch pulse
  input wire logic load_valid, // load_task_register_instruction retires
  input wire logic [63:0] load_base, // block base for task_register
  output logic [63:0] task_reg_base_q, // task_register base
  output logic task_reg_long_q, // task_register holds a 64-bit block
  input wire task_block_pkg::field_req_t field_req, // 64-bit block field lookup
  output logic field_busy_q, // lookup in flight
  output logic field_done_q, // lookup result pulse
  output logic field_err_q, // lookup refused pulse
  output logic [63:0] field_value_q, // lookup result
  output logic rd_valid_q, // memory read request
  output logic [63:0] rd_addr_q, // memory read address
  input wire logic rd_ack, // memory read data valid
  input wire logic [31:0] rd_data, // memory read data
  input wire task_block_pkg::legacy_save_t save, // legacy block store request
  output logic save_busy_q, // store in flight
  output logic wr_valid_q, // 16-bit memory write request
  output logic [63:0] wr_addr_q, // memory write address
  output logic [15:0] wr_data_q, // memory write data
  input wire logic wr_ack // memory write accepted
);
  import task_block_pkg::*;

  // ==========================================
  // address helpers
  function automatic logic [7:0] field_offset(input field_sel_t sel, input logic [2:0] index);
    logic [7:0] ofs;
    ofs = IO_MAP_OFS;
    unique case (sel)
      FLD_RING_STACK: ofs = RING_STACK_OFS + 8'(index * PTR_STRIDE);
      FLD_ALT_STACK: ofs = ALT_STACK_OFS + 8'((index - ALT_INDEX_MIN) * PTR_STRIDE);
      FLD_IO_MAP: ofs = IO_MAP_OFS;
      default: ofs = IO_MAP_OFS;
    endcase
    return ofs;
  endfunction

  function automatic logic field_legal(input field_sel_t sel, input logic [2:0] index);
    logic ok;
    ok = 1'b0;
    unique case (sel)
      FLD_RING_STACK: ok = (index <= RING_LEVEL_MAX);
      FLD_ALT_STACK: ok = (index >= ALT_INDEX_MIN) && (index <= ALT_INDEX_MAX);
      FLD_IO_MAP: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // ==========================================
  // task switch trap
  logic gp_fault_d, task_switch_d;
  logic to_task, nested_return;

  always_comb begin
    to_task = xfer.valid && xfer.kind != XFER_INT_RETURN && xfer.target != TGT_OTHER;
    nested_return = xfer.valid && xfer.kind == XFER_INT_RETURN && nested_task_flag;
    // long mode has no hardware task switch; software must do it
    gp_fault_d = long_mode && (to_task || nested_return);
    task_switch_d = !long_mode && (to_task || nested_return);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gp_fault_q <= 1'b0;
      task_switch_q <= 1'b0;
    end else begin
      gp_fault_q <= gp_fault_d;
      task_switch_q <= task_switch_d;
    end
  end

  // ==========================================
  // task register
  logic [63:0] task_reg_base_d;
  logic task_reg_long_d;

  always_comb begin
    task_reg_base_d = task_reg_base_q;
    task_reg_long_d = task_reg_long_q;
    if (load_valid) begin
      task_reg_base_d = load_base;
      task_reg_long_d = long_mode;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      task_reg_base_q <= TASK_REG_BASE_RESET;
      task_reg_long_q <= 1'b0;
    end else begin
      task_reg_base_q <= task_reg_base_d;
      task_reg_long_q <= task_reg_long_d;
    end
  end

  // ==========================================
  // 64-bit field lookup
  logic fetch_start, fetch_busy, fetch_done, field_err_d;
  logic [63:0] fetch_value, fetch_addr;

  always_comb begin
    // only a block loaded in long mode is read; one lookup at a time
    fetch_start = field_req.valid && !fetch_busy && task_reg_long_q
                  && field_legal(field_req.sel, field_req.index);
    field_err_d = field_req.valid && !fetch_busy
                  && !(task_reg_long_q && field_legal(field_req.sel, field_req.index));
    fetch_addr = task_reg_base_q + {56'h0, field_offset(field_req.sel, field_req.index)};
  end

  block_field_fetch u_fetch (
    .clk(clk),
    .reset_n(reset_n),
    .start(fetch_start),
    .start_addr(fetch_addr),
    .half_only(field_req.sel == FLD_IO_MAP),
    .busy_q(fetch_busy),
    .done_q(fetch_done),
    .value_q(fetch_value),
    .rd_valid_q(rd_valid_q),
    .rd_addr_q(rd_addr_q),
    .rd_ack(rd_ack),
    .rd_data(rd_data)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      field_err_q <= 1'b0;
    end else begin
      field_err_q <= field_err_d;
    end
  end

  assign field_busy_q = fetch_busy;
  assign field_done_q = fetch_done;
  assign field_value_q = fetch_value;

  // ==========================================
  // legacy 16-bit block store
  logic wr_valid_d, save_busy_d;
  logic [63:0] wr_addr_d;
  logic [15:0] wr_data_d;

  always_comb begin
    wr_valid_d = wr_valid_q;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    save_busy_d = save_busy_q;
    if (save_busy_q) begin
      if (wr_ack) begin
        wr_valid_d = 1'b0;
        save_busy_d = 1'b0;
      end
    end else if (save.valid) begin
      wr_valid_d = 1'b1;
      save_busy_d = 1'b1;
      wr_addr_d = task_reg_base_q + {56'h0, 8'(save.slot * LEGACY_STRIDE)};
      // a 16-bit block has no room for upper halves; they are lost
      wr_data_d = save.value[15:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_valid_q <= 1'b0;
      wr_addr_q <= 64'h0000_0000_0000_0000;
      wr_data_q <= 16'h0000;
      save_busy_q <= 1'b0;
    end else begin
      wr_valid_q <= wr_valid_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      save_busy_q <= save_busy_d;
    end
  end

  // ==========================================
  // checks
  sequence task_xfer_long_s;
    long_mode && xfer.valid && xfer.kind != XFER_INT_RETURN && xfer.target != TGT_OTHER;
  endsequence

  gp_task_xfer_a: assert property (@(posedge clk) disable iff (!reset_n)
    task_xfer_long_s |=> gp_fault_q && !task_switch_q)
    else $error("task transfer in long mode did not fault");

  gp_nested_interrupt_return_instruction_a: assert property (@(posedge clk) disable iff (!reset_n)
    (long_mode && xfer.valid && xfer.kind == XFER_INT_RETURN) |=> gp_fault_q == $past(nested_task_flag))
    else $error("interrupt return fault does not follow nested flag");

  no_long_switch_a: assert property (@(posedge clk) disable iff (!reset_n)
    task_switch_q |-> !$past(long_mode))
    else $error("hardware task switch in long mode");

  ring_zero_addr_a: assert property (@(posedge clk) disable iff (!reset_n)
    (fetch_start && field_req.sel == FLD_RING_STACK && field_req.index == 3'h0)
    |=> rd_addr_q == task_reg_base_q + 64'h0000_0000_0000_0004)
    else $error("ring 0 pointer not at byte 4");

  alt_index_range_a: assert property (@(posedge clk) disable iff (!reset_n)
    (field_req.valid && !fetch_busy && field_req.sel == FLD_ALT_STACK && field_req.index == 3'h0)
    |=> field_err_q && !rd_valid_q)
    else $error("alternate stack index 0 accepted");

  io_map_width_a: assert property (@(posedge clk) disable iff (!reset_n)
    (fetch_start && field_req.sel == FLD_IO_MAP)
    |=> rd_addr_q == task_reg_base_q + 64'h0000_0000_0000_0064 ##1 (field_value_q[63:16] == 48'h0 || !field_done_q))
    else $error("io map base not a 16-bit field of the last word");

  tr_load_a: assert property (@(posedge clk) disable iff (!reset_n)
    load_valid |=> task_reg_base_q == $past(load_base) && task_reg_long_q == $past(long_mode))
    else $error("task register not loaded");

  legacy_store_a: assert property (@(posedge clk) disable iff (!reset_n)
    (save.valid && !save_busy_q && save.slot == LEG_FLAGS)
    |=> wr_valid_q && wr_addr_q == task_reg_base_q + 64'h0000_0000_0000_0010 && wr_data_q == $past(save.value[15:0]))
    else $error("legacy flag word stored wrong");

endmodule

// file: common/tss_pkg.sv
// package: task state block layout, request carriers and trap encodings
package task_block_pkg;

  // ==========================================
  // 64-bit task state block layout (byte offsets, io map bit position, ring level and alternate index limits)
  localparam logic [7:0] RING_STACK_OFS = 8'h04;
  localparam logic [7:0] ALT_STACK_OFS = 8'h24;
  localparam logic [7:0] PTR_STRIDE = 8'h08;
  localparam logic [7:0] HALF_OFS = 8'h04;
  localparam logic [7:0] IO_MAP_OFS = 8'h64;
  localparam int IO_MAP_LSB = 16;
  localparam logic [2:0] RING_LEVEL_MAX = 3'h2;
  localparam logic [2:0] ALT_INDEX_MIN = 3'h1;
  localparam logic [2:0] ALT_INDEX_MAX = 3'h7;

  // ==========================================
  // legacy 16-bit block: slot code times stride is the byte offset
  localparam logic [7:0] LEGACY_STRIDE = 8'h02;
  localparam logic [63:0] TASK_REG_BASE_RESET = 64'h0000_0000_0000_0000;

  typedef enum logic [4:0] {
    LEG_LINK = 5'h00, LEG_SP0 = 5'h01, LEG_SS0 = 5'h02, LEG_SP1 = 5'h03,
    LEG_SS1 = 5'h04, LEG_SP2 = 5'h05, LEG_SS2 = 5'h06, LEG_IP = 5'h07,
    LEG_FLAGS = 5'h08, LEG_AX = 5'h09, LEG_CX = 5'h0A, LEG_DX = 5'h0B,
    LEG_BX = 5'h0C, LEG_SP = 5'h0D, LEG_BP = 5'h0E, LEG_SI = 5'h0F,
    LEG_DI = 5'h10, LEG_ES = 5'h11, LEG_CS = 5'h12, LEG_SS = 5'h13,
    LEG_DS = 5'h14, LEG_LOCAL_TABLE = 5'h15
  } legacy_slot_t;

  typedef enum logic [2:0] {
    XFER_JUMP = 3'h0,
    XFER_CALL = 3'h1,
    XFER_SWINT = 3'h2,
    XFER_HWINT = 3'h3,
    XFER_INT_RETURN = 3'h4
  } xfer_kind_t;

  typedef enum logic [1:0] {
    TGT_OTHER = 2'h0,
    TGT_TASK_BLOCK = 2'h1,
    TGT_TASK_GATE = 2'h2
  } xfer_target_t;

  typedef enum logic [1:0] {
    FLD_RING_STACK = 2'h0,
    FLD_ALT_STACK = 2'h1,
    FLD_IO_MAP = 2'h2
  } field_sel_t;

  typedef struct packed {
    logic valid;
    xfer_kind_t kind;
    xfer_target_t target;
  } xfer_req_t;

  typedef struct packed {
    logic valid;
    field_sel_t sel;
    logic [2:0] index;
  } field_req_t;

  typedef struct packed {
    logic valid;
    legacy_slot_t slot;
    logic [31:0] value;
  } legacy_save_t;

endpackage

// file: src/tss_field_fetch.sv
// two-read fetch of one 64-bit task state block field, or one read for the 16-bit io map base
`timescale 1ns/1ps
module block_field_fetch (
  input wire logic clk, // core clock
  input wire logic reset_n, // async reset, active low
  input wire logic start, // one-cycle start, only while idle
  input wire logic [63:0] start_addr, // address of the lower half
  input wire logic half_only, // field is a single upper-half word
  output logic busy_q, // fetch in flight
  output logic done_q, // one-cycle result pulse
  output logic [63:0] value_q, // assembled field
  output logic rd_valid_q, // read request, held until ack
  output logic [63:0] rd_addr_q, // read byte address
  input wire logic rd_ack, // read data valid
  input wire logic [31:0] rd_data // read data
);
  import task_block_pkg::*;

  typedef enum logic [1:0] {F_IDLE = 2'h0, F_LOW = 2'h1, F_HIGH = 2'h2} fetch_state_t;

  fetch_state_t state_q, state_d;
  logic [31:0] low_q, low_d;
  logic done_d, rd_valid_d, busy_d;
  logic [63:0] value_d, rd_addr_d;
  logic half_q, half_d;

  // ==========================================
  // next state
  always_comb begin
    state_d = state_q;
    low_d = low_q;
    half_d = half_q;
    done_d = 1'b0;
    value_d = value_q;
    rd_valid_d = rd_valid_q;
    rd_addr_d = rd_addr_q;
    unique case (state_q)
      F_IDLE: begin
        if (start) begin
          state_d = F_LOW;
          half_d = half_only;
          rd_valid_d = 1'b1;
          rd_addr_d = start_addr;
        end
      end
      F_LOW: begin
        if (rd_ack) begin
          low_d = rd_data;
          if (half_q) begin
            // io map base: upper half of the word, zero extended
            rd_valid_d = 1'b0;
            value_d = {48'h0000_0000_0000, rd_data[31:IO_MAP_LSB]};
            done_d = 1'b1;
            state_d = F_IDLE;
          end else begin
            rd_addr_d = rd_addr_q + {56'h0, HALF_OFS};
            state_d = F_HIGH;
          end
        end
      end
      F_HIGH: begin
        if (rd_ack) begin
          rd_valid_d = 1'b0;
          value_d = {rd_data, low_q};
          done_d = 1'b1;
          state_d = F_IDLE;
        end
      end
      default: state_d = F_IDLE;
    endcase
    busy_d = (state_d != F_IDLE);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= F_IDLE;
      busy_q <= 1'b0;
      low_q <= 32'h0000_0000;
      half_q <= 1'b0;
      done_q <= 1'b0;
      value_q <= 64'h0000_0000_0000_0000;
      rd_valid_q <= 1'b0;
      rd_addr_q <= 64'h0000_0000_0000_0000;
    end else begin
      state_q <= state_d;
      busy_q <= busy_d;
      low_q <= low_d;
      half_q <= half_d;
      done_q <= done_d;
      value_q <= value_d;
      rd_valid_q <= rd_valid_d;
      rd_addr_q <= rd_addr_d;
    end
  end


  // ==========================================
  // checks
  sequence low_taken_s;
    rd_valid_q && rd_ack && state_q == F_LOW && !half_q;
  endsequence

  low_then_high_a: assert property (@(posedge clk) disable iff (!reset_n)
    low_taken_s |=> rd_valid_q && rd_addr_q == $past(rd_addr_q) + 64'h0000_0000_0000_0004)
    else $error("upper half not read from the next word");

  join_halves_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rd_ack && state_q == F_HIGH) |=> done_q && value_q[31:0] == $past(low_q))
    else $error("halves joined in wrong order");

  io_upper_half_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rd_ack && state_q == F_LOW && half_q) |=> done_q && value_q == {48'h0000_0000_0000, $past(rd_data[31:16])})
    else $error("io map base not taken from the upper half");

endmodule

// file: bench/testbench.sv
// self-checking bench for the long mode task switch guard
`timescale 1ns/1ps
module testbench;
  import task_block_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic long_mode = 1'b0;
  logic nested_task_flag = 1'b0;
  xfer_req_t xfer = '0;
  logic load_valid = 1'b0;
  logic [63:0] load_base = '0;
  field_req_t field_req = '0;
  logic rd_ack = 1'b0;
  logic [31:0] rd_data = '0;
  legacy_save_t save = '0;
  logic wr_ack = 1'b0;
  logic gp_fault_q, task_switch_q, task_reg_long_q, field_busy_q, field_done_q, field_err_q;
  logic rd_valid_q, save_busy_q, wr_valid_q;
  logic [63:0] task_reg_base_q, field_value_q, rd_addr_q, wr_addr_q;
  logic [15:0] wr_data_q;
  int error_cnt = 0;
  int tests_run = 0;
  logic [63:0] tb_base;

  always #5 clk = ~clk;

  task_switch_guard dut_u (
    .clk(clk), .reset_n(reset_n), .long_mode(long_mode), .nested_task_flag(nested_task_flag),
    .xfer(xfer), .gp_fault_q(gp_fault_q), .task_switch_q(task_switch_q), .load_valid(load_valid),
    .load_base(load_base), .task_reg_base_q(task_reg_base_q), .task_reg_long_q(task_reg_long_q),
    .field_req(field_req),
    .field_busy_q(field_busy_q), .field_done_q(field_done_q), .field_err_q(field_err_q),
    .field_value_q(field_value_q), .rd_valid_q(rd_valid_q), .rd_addr_q(rd_addr_q), .rd_ack(rd_ack),
    .rd_data(rd_data), .save(save), .save_busy_q(save_busy_q), .wr_valid_q(wr_valid_q),
    .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q), .wr_ack(wr_ack)
  );

  // ==========================================
  // checking and closing
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // memory content is address-derived so a wrong address shows as wrong data
  function automatic logic [31:0] pat(input logic [63:0] a);
    return {a[15:0] ^ 16'h5A3C, a[15:0]};
  endfunction

  // ==========================================
  // access tasks
  task automatic do_xfer(input xfer_kind_t k, input xfer_target_t t, input logic lm, input logic nflag,
                         input logic exp_gp, input logic exp_ts);
    @(negedge clk);
    xfer = '{1'b1, k, t};
    long_mode = lm;
    nested_task_flag = nflag;
    @(negedge clk);
    xfer = '0;
    check("gp_fault", gp_fault_q, exp_gp);
    check("task_switch", task_switch_q, exp_ts);
    @(negedge clk);
    check("gp_fault_end", gp_fault_q, 1'b0);
    check("task_switch_end", task_switch_q, 1'b0);
  endtask

  task automatic do_load(input logic [63:0] b, input logic lm);
    @(negedge clk);
    load_valid = 1'b1;
    load_base = b;
    long_mode = lm;
    @(negedge clk);
    load_valid = 1'b0;
    check("task_reg_base", task_reg_base_q, b);
    check("task_reg_long", task_reg_long_q, lm);
  endtask

  // words: 0 means refusal expected, 1 io map, 2 pointer
  task automatic fetch(input field_sel_t s, input logic [2:0] idx, input logic [63:0] ofs, input int words,
                       input int stall);
    logic [63:0] exp_v;
    int n;
    @(negedge clk);
    field_req = '{1'b1, s, idx};
    @(negedge clk);
    field_req = '0;
    if (words == 0) begin
      check("field_err", field_err_q, 1'b1);
      check("rd_valid_idle", rd_valid_q, 1'b0);
      return;
    end
    check("field_err_ok", field_err_q, 1'b0);
    check("field_busy", field_busy_q, 1'b1);
    exp_v = '0;
    for (int w = 0; w < words; w++) begin
      for (n = 0; n < 20 && rd_valid_q !== 1'b1; n++) @(negedge clk);
      check("rd_addr", rd_addr_q, tb_base + ofs + 64'(4 * w));
      for (n = 0; n < stall; n++) begin
        // a lookup made while busy is dropped without a refusal
        if (n == 0) field_req = '{1'b1, FLD_RING_STACK, 3'h7};
        else field_req = '0;
        @(negedge clk);
        check("busy_drop_err", field_err_q, 1'b0);
      end
      if (stall > 0) field_req = '0;
      // request must stand while memory is slow
      check("rd_held", rd_valid_q, 1'b1);
      rd_ack = 1'b1;
      rd_data = pat(rd_addr_q);
      exp_v = (words == 1) ? {48'h0, rd_data[31:16]} : {rd_data, exp_v[63:32]};
      @(negedge clk);
      // with no stall the ack stands on into the next word instead of toggling in one step
      if (w == words - 1 || stall > 0) begin
        rd_ack = 1'b0;
        rd_data = 32'hDEAD_BEEF;
      end
    end
    check("field_done", field_done_q, 1'b1);
    check("field_value", field_value_q, exp_v);
    check("field_busy_end", field_busy_q, 1'b0);
    check("rd_valid_end", rd_valid_q, 1'b0);
  endtask

  task automatic do_save(input legacy_slot_t sl, input logic [31:0] v);
    @(negedge clk);
    save = '{1'b1, sl, v};
    @(negedge clk);
    save = '0;
    check("wr_valid", wr_valid_q, 1'b1);
    check("save_busy", save_busy_q, 1'b1);
    check("wr_addr", wr_addr_q, tb_base + 64'(2 * int'(sl)));
    check("wr_data", wr_data_q, v[15:0]);
    wr_ack = 1'b1;
    @(negedge clk);
    wr_ack = 1'b0;
    check("wr_valid_end", wr_valid_q, 1'b0);
    check("save_busy_end", save_busy_q, 1'b0);
  endtask

  // ==========================================
  // main sequence
  initial begin
    tb_base = 64'h0000_7F00_1234_5000;
    repeat (16) @(negedge clk);
    check("rst_task_base", task_reg_base_q, TASK_REG_BASE_RESET);
    check("rst_rd_valid", rd_valid_q, 1'b0);
    check("rst_wr_valid", wr_valid_q, 1'b0);
    reset_n = 1'b1;
    // lookups refused until a block is loaded in long mode
    fetch(FLD_RING_STACK, 3'h0, 64'h0, 0, 0);
    do_load(64'h0000_0000_0000_8000, 1'b0);
    fetch(FLD_ALT_STACK, 3'h1, 64'h0, 0, 0);
    do_load(tb_base, 1'b1);
    for (int lm = 0; lm < 2; lm++) begin
      for (int k = 0; k < 4; k++) begin
        for (int t = 0; t < 3; t++) begin
          do_xfer(xfer_kind_t'(k), xfer_target_t'(t), lm[0], 1'b0, lm[0] && t != 0, !lm[0] && t != 0);
        end
      end
      for (int nf = 0; nf < 2; nf++) begin
        do_xfer(XFER_INT_RETURN, TGT_OTHER, lm[0], nf[0], lm[0] && nf[0], !lm[0] && nf[0]);
      end
    end
    long_mode = 1'b1;
    for (int r = 0; r < 3; r++) fetch(FLD_RING_STACK, r[2:0], 64'(4 + 8 * r), 2, r);
    fetch(FLD_RING_STACK, 3'h3, 64'h0, 0, 0);
    for (int a = 1; a < 8; a++) fetch(FLD_ALT_STACK, a[2:0], 64'(36 + 8 * (a - 1)), 2, a % 3);
    fetch(FLD_ALT_STACK, 3'h0, 64'h0, 0, 0);
    fetch(FLD_IO_MAP, 3'h0, 64'h64, 1, 2);
    for (int s = 0; s < 22; s++) do_save(legacy_slot_t'(s), {16'hFFFF - 16'(s), 16'h1230 + 16'(s)});
    do_save(LEG_FLAGS, 32'h1234_5678);
    do_save(LEG_IP, 32'hFFFF_0042);
    // a reset in mid-run must forget the loaded block
    @(negedge clk);
    reset_n = 1'b0;
    @(negedge clk);
    check("rst2_task_base", task_reg_base_q, TASK_REG_BASE_RESET);
    check("rst2_task_long", task_reg_long_q, 1'b0);
    reset_n = 1'b1;
    fetch(FLD_IO_MAP, 3'h0, 64'h0, 0, 0);
    end_sim();
  end

  // whole run is a few hundred cycles; this bound only cuts a hang
  initial begin
    #200000;
    error_cnt++;
    $display("[ERR] watchdog expected finish seen timeout");
    end_sim();
  end
endmodule
